/* logic/ccp_link_if.sv */
// configuration-channel link between a port and its partner
// every wire is an on-chip level on the shared clock; nothing resolves pulls, each pull is its own wire
`timescale 1ns/1ps
interface ccp_link_if;
   logic port_pull_up;
   logic port_pull_down;
   logic port_vbus_on;
   logic port_vconn_on;
   logic port_id_query;
   logic far_pull_up;
   logic far_pull_down;
   logic far_id_valid;
   logic far_id_vconn_pwr;
   logic far_id_charge_thru;

   modport port (
      output port_pull_up, port_pull_down, port_vbus_on, port_vconn_on, port_id_query,
      input far_pull_up, far_pull_down, far_id_valid, far_id_vconn_pwr, far_id_charge_thru
   );
   modport partner (
      input port_pull_up, port_pull_down, port_vbus_on, port_vconn_on, port_id_query,
      output far_pull_up, far_pull_down, far_id_valid, far_id_vconn_pwr, far_id_charge_thru
   );
endinterface

/* logic/ccp_partner.sv */
// partner end: vconn-powered device, or legacy host adapter
// assumes the port drives its link levels from flip-flops on the same clock
`timescale 1ns/1ps
module ccp_partner
   import ccp_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic legacy_host_i,
   input wire logic charge_thru_i,
   input wire logic [CNT_W-1:0] debounce_cyc_i,
   output logic attached_o,
   output logic default_power_o,
   ccp_link_if.partner link
);
   ////////////////////////////////////////////////////////////////////////////////
   ccp_vstate_t state, next_state;
   logic [CNT_W-1:0] cnt, next_cnt;
   logic up, next_up, dn, next_dn, idv, next_idv, att, next_att, dflt, next_dflt;

   always_comb begin
      next_state = state;
      next_cnt = (cnt == CNT_ZERO) ? CNT_ZERO : cnt - CNT_ONE;
      next_idv = 1'b0;
      case (state)
         CCP_V_UNATT: begin
            if (!legacy_host_i && link.port_vconn_on) begin
               next_state = CCP_V_AW;
               next_cnt = (debounce_cyc_i == CNT_ZERO) ? CNT_ONE : debounce_cyc_i;
            end
         end
         CCP_V_AW: begin
            if (!link.port_vconn_on) begin
               next_state = CCP_V_UNATT;
            end else if (cnt == CNT_ZERO) begin
               next_state = CCP_V_ATT;
            end
         end
         CCP_V_ATT: begin
            if (!link.port_vconn_on) begin
               next_state = CCP_V_UNATT;
            end
            next_idv = link.port_id_query;
         end
         default: begin
            next_state = CCP_V_UNATT;
         end
      endcase
      // legacy adapter: fixed pull-up advertising default power only
      next_up = legacy_host_i;
      next_dn = !legacy_host_i;
      next_dflt = legacy_host_i;
      next_att = (next_state == CCP_V_ATT);
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state <= CCP_V_UNATT;
         cnt <= CNT_ZERO;
         up <= 1'b0;
         dn <= 1'b0;
         idv <= 1'b0;
         att <= 1'b0;
         dflt <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         up <= next_up;
         dn <= next_dn;
         idv <= next_idv;
         att <= next_att;
         dflt <= next_dflt;
      end
   end

   assign link.far_pull_up = up;
   assign link.far_pull_down = dn;
   assign link.far_id_valid = idv;
   assign link.far_id_vconn_pwr = idv;
   assign link.far_id_charge_thru = idv & charge_thru_i;
   assign attached_o = att;
   assign default_power_o = dflt;
endmodule

/* logic/ccp_pkg.sv */
// package for the connection-detection state machine of a reversible port
// assumes one 200 MHz clock shared by both ends of the link
package ccp_pkg;
   localparam int unsigned CLK_MHZ = 200;
   localparam int unsigned DEBOUNCE_US = 100;
   localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
   localparam int unsigned TOGGLE_US = 50;
   localparam int unsigned TOGGLE_CYC = TOGGLE_US * CLK_MHZ;
   localparam int CNT_W = 24;
   localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;
   localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;

   typedef enum logic [1:0] {
      CCP_ROLE_SOURCE,
      CCP_ROLE_SINK,
      CCP_ROLE_DUAL
   } ccp_role_t;

   typedef enum {
      CCP_UNATT_SRC,
      CCP_AW_SRC,
      CCP_ATT_SRC,
      CCP_UNATT_SNK,
      CCP_AW_SNK,
      CCP_ATT_SNK,
      CCP_TRY_SINK,
      CCP_TRYW_SRC
   } ccp_state_t;

   typedef enum {
      CCP_V_UNATT,
      CCP_V_AW,
      CCP_V_ATT
   } ccp_vstate_t;
endpackage

/* logic/ccp_port.sv */
// connection-detection state machine of the port: source, sink or dual role
// assumes link inputs arrive from the partner asynchronously and are synchronised here
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module ccp_port
   import ccp_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire ccp_role_t role_i,
   input wire logic prefer_sink_i,
   input wire logic capable_sink_i,
   input wire logic vpd_support_i,
   input wire logic vbus_present_i,
   input wire logic [CNT_W-1:0] debounce_cyc_i,
   input wire logic [CNT_W-1:0] toggle_cyc_i,
   output logic attached_source_o,
   output logic attached_sink_o,
   output logic vpd_found_o,
   ccp_link_if.port link
);
   ////////////////////////////////////////////////////////////////////////////////
   logic [1:0] sync_up, sync_dn, sync_vb, sync_idv, sync_idp, sync_idc;
   logic cc_up, cc_dn, vb, idv, idp, idc;

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         sync_up <= 2'h0;
         sync_dn <= 2'h0;
         sync_vb <= 2'h0;
         sync_idv <= 2'h0;
         sync_idp <= 2'h0;
         sync_idc <= 2'h0;
      end else begin
         sync_up <= {sync_up[0], link.far_pull_up};
         sync_dn <= {sync_dn[0], link.far_pull_down};
         sync_vb <= {sync_vb[0], vbus_present_i};
         sync_idv <= {sync_idv[0], link.far_id_valid};
         sync_idp <= {sync_idp[0], link.far_id_vconn_pwr};
         sync_idc <= {sync_idc[0], link.far_id_charge_thru};
      end
   end
   assign cc_up = sync_up[1];
   assign cc_dn = sync_dn[1];
   assign vb = sync_vb[1];
   assign idv = sync_idv[1];
   assign idp = sync_idp[1];
   assign idc = sync_idc[1];

   ////////////////////////////////////////////////////////////////////////////////
   ccp_state_t state, next_state;
   logic [CNT_W-1:0] cnt, next_cnt;
   logic cc_last, next_cc_last;
   logic vbus_kill, next_vbus_kill;
   logic queried, next_queried;
   logic pu, next_pu, pd, next_pd, vbon, next_vbon, vcon, next_vcon, q, next_q;
   logic att_src, next_att_src, att_snk, next_att_snk, vconn_powered_device, next_vpd;

   function automatic logic [CNT_W-1:0] cnt_load(input logic [CNT_W-1:0] v);
      cnt_load = (v == CNT_ZERO) ? CNT_ONE : v;
   endfunction

   // entry into an unattached, waiting or trial state reloads the timer; sink-side unattached state unless the role is source-only
   function automatic ccp_state_t detach_to(input ccp_role_t r);
      detach_to = (r == CCP_ROLE_SOURCE) ? CCP_UNATT_SRC : CCP_UNATT_SNK;
   endfunction

   logic cc_now, done;

   always_comb begin
      next_state = state;
      next_cnt = (cnt == CNT_ZERO) ? CNT_ZERO : cnt - CNT_ONE;
      next_vbus_kill = vbus_kill;
      next_queried = queried;
      cc_now = (state == CCP_AW_SNK || state == CCP_TRY_SINK) ? cc_up : cc_dn;
      next_cc_last = cc_now;
      done = (cnt == CNT_ZERO);
      case (state)
         CCP_UNATT_SRC: begin
            // a role change made while unattached must not strand the port
            if (role_i == CCP_ROLE_SINK) begin
               next_state = CCP_UNATT_SNK;
               next_cnt = cnt_load(toggle_cyc_i);
            end else if (cc_dn) begin
               next_state = CCP_AW_SRC;
               next_cnt = cnt_load(debounce_cyc_i);
            end else if (role_i == CCP_ROLE_DUAL && done) begin
               next_state = CCP_UNATT_SNK;
               next_cnt = cnt_load(toggle_cyc_i);
            end
            // source-only role simply waits here with power off
         end
         CCP_AW_SRC: begin
            if (!cc_dn) begin
               next_state = detach_to(role_i);
               next_cnt = cnt_load(toggle_cyc_i);
            end else if (cc_now != cc_last) begin
               next_cnt = cnt_load(debounce_cyc_i);
            end else if (done) begin
               if (role_i == CCP_ROLE_DUAL && prefer_sink_i) begin
                  next_state = CCP_TRY_SINK;
               end else begin
                  next_state = CCP_ATT_SRC;
               end
               next_cnt = cnt_load(debounce_cyc_i);
               next_vbus_kill = 1'b0;
               next_queried = 1'b0;
            end
         end
         CCP_ATT_SRC: begin
            if (!cc_dn) begin
               next_state = detach_to(role_i);
               next_cnt = cnt_load(toggle_cyc_i);
            end else if (idv && idp && !idc) begin
               next_vbus_kill = 1'b1;
            end
            if (role_i == CCP_ROLE_DUAL && vpd_support_i && !queried) begin
               next_queried = 1'b1;
            end
         end
         CCP_UNATT_SNK: begin
            // reset lands here, so a source-only port leaves at once
            if (role_i == CCP_ROLE_SOURCE) begin
               next_state = CCP_UNATT_SRC;
               next_cnt = cnt_load(toggle_cyc_i);
            end else if (cc_up) begin
               next_state = CCP_AW_SNK;
               next_cnt = cnt_load(debounce_cyc_i);
            end else if (vb && !capable_sink_i && role_i == CCP_ROLE_SINK) begin
               next_state = CCP_ATT_SNK;
            end else if (role_i == CCP_ROLE_DUAL && done) begin
               next_state = CCP_UNATT_SRC;
               next_cnt = cnt_load(toggle_cyc_i);
            end
            // sink-only role with nothing seen stays here
         end
         CCP_AW_SNK: begin
            if (!cc_up) begin
               next_state = (role_i == CCP_ROLE_DUAL) ? CCP_UNATT_SRC : CCP_UNATT_SNK;
               next_cnt = cnt_load(toggle_cyc_i);
            end else if (cc_now != cc_last) begin
               next_cnt = cnt_load(debounce_cyc_i);
            end else if (done && vb) begin
               next_state = CCP_ATT_SNK;
            end
         end
         CCP_ATT_SNK: begin
            if (!vb) begin
               next_state = CCP_UNATT_SNK;
               next_cnt = cnt_load(toggle_cyc_i);
            end
         end
         CCP_TRY_SINK: begin
            // partner pull-up keeps us here; it attaches once VBUS follows
            if (cc_up && done && vb) begin
               next_state = CCP_ATT_SNK;
            end else if (!cc_up && done) begin
               next_state = CCP_TRYW_SRC;
               next_cnt = cnt_load(debounce_cyc_i);
            end
         end
         CCP_TRYW_SRC: begin
            if (cc_dn && done) begin
               next_state = CCP_ATT_SRC;
               next_vbus_kill = 1'b0;
               next_queried = 1'b0;
            end else if (!cc_dn && done) begin
               next_state = CCP_UNATT_SNK;
               next_cnt = cnt_load(toggle_cyc_i);
            end
         end
         default: begin
            next_state = detach_to(role_i);
         end
      endcase
      // outputs follow the state being entered so they settle with it
      next_pu = (next_state == CCP_UNATT_SRC || next_state == CCP_AW_SRC ||
                 next_state == CCP_ATT_SRC || next_state == CCP_TRYW_SRC);
      next_pd = !next_pu;
      next_vbon = (next_state == CCP_ATT_SRC) && !next_vbus_kill;
      next_vcon = (next_state == CCP_ATT_SRC);
      next_q = (next_state == CCP_ATT_SRC) && next_queried && !next_vbus_kill;
      next_att_src = (next_state == CCP_ATT_SRC);
      next_att_snk = (next_state == CCP_ATT_SNK);
      next_vpd = (next_state == CCP_ATT_SRC) && next_vbus_kill;
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state <= CCP_UNATT_SNK;
         cnt <= CNT_ZERO;
         cc_last <= 1'b0;
         vbus_kill <= 1'b0;
         queried <= 1'b0;
         pu <= 1'b0;
         pd <= 1'b1;
         vbon <= 1'b0;
         vcon <= 1'b0;
         q <= 1'b0;
         att_src <= 1'b0;
         att_snk <= 1'b0;
         vconn_powered_device <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         cc_last <= next_cc_last;
         vbus_kill <= next_vbus_kill;
         queried <= next_queried;
         pu <= next_pu;
         pd <= next_pd;
         vbon <= next_vbon;
         vcon <= next_vcon;
         q <= next_q;
         att_src <= next_att_src;
         att_snk <= next_att_snk;
         vconn_powered_device <= next_vpd;
      end
   end

   assign link.port_pull_up = pu;
   assign link.port_pull_down = pd;
   assign link.port_vbus_on = vbon;
   assign link.port_vconn_on = vcon;
   assign link.port_id_query = q;
   assign attached_source_o = att_src;
   assign attached_sink_o = att_snk;
   assign vpd_found_o = vconn_powered_device;
endmodule

/* sim/ccp_link_monitor.sv */
// checker on the link between the port and its partner
// assumes a port debounce of 8 cycles and link levels on one shared clock
`timescale 1ns/1ps
module ccp_link_monitor (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic port_pull_up,
   input wire logic port_pull_down,
   input wire logic port_vbus_on,
   input wire logic port_vconn_on,
   input wire logic port_id_query,
   input wire logic far_pull_up,
   input wire logic far_pull_down,
   input wire logic far_id_valid,
   input wire logic far_id_vconn_pwr,
   input wire logic far_id_charge_thru
);
   localparam logic [7:0] DEB = 8'h08;
   localparam logic [7:0] GAP = 8'h28;
   logic [7:0] dn_run;
   logic [7:0] dn_gap;
   logic [7:0] next_dn_run;
   logic [7:0] next_dn_gap;
   ////////////////////////////////////////////////////////////////////////////////
   // run lengths of the far pull-down; saturate so a long attach never wraps
   always_comb begin
      next_dn_run = far_pull_down ? dn_run + {7'h00, dn_run != 8'hff} : 8'h00;
      next_dn_gap = far_pull_down ? 8'h00 : dn_gap + {7'h00, dn_gap != 8'hff};
   end
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         dn_run <= 8'h00;
         dn_gap <= 8'h00;
      end else begin
         dn_run <= next_dn_run;
         dn_gap <= next_dn_gap;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   sequence s_device_reply;
      (port_id_query && far_id_valid && far_id_vconn_pwr && !far_id_charge_thru) [*2];
   endsequence
   sequence s_device_settled;
      !port_vbus_on && !port_id_query && port_pull_up && port_vconn_on;
   endsequence
   a_one_term: assert property (port_pull_up != port_pull_down)
      else $error("port shows both or neither termination");
   a_vbus_source: assert property (port_vbus_on |-> port_pull_up && port_vconn_on)
      else $error("vbus on outside attached source");
   a_vconn_source: assert property (port_vconn_on |-> port_pull_up)
      else $error("vconn on without pull-up");
   a_power_debounce: assert property ($rose(port_vbus_on) |-> dn_run >= DEB)
      else $error("vbus switched on before debounce");
   a_query_source: assert property (port_id_query |-> port_pull_up && port_vconn_on)
      else $error("identity query outside attached source");
   a_reply_cuts_vbus: assert property (s_device_reply |-> ##[1:8] s_device_settled)
      else $error("vbus not removed after powered device reply");
   a_vbus_stays_off: assert property (
      !port_vbus_on && port_vconn_on && far_pull_down |=> !port_vbus_on)
      else $error("vbus came back while powered device attached");
   a_detach_off: assert property (
      dn_gap >= GAP |-> !port_vbus_on && !port_vconn_on && !port_id_query)
      else $error("source power kept without partner pull-down");
endmodule

/* sim/tb_top.sv */
// bench: port and partner joined by the link; holding partner reset acts as unplug
// assumes 200 MHz clock, debounce 8 and toggle half 16 cycles
`timescale 1ns/1ps
module tb_top;
   import ccp_pkg::*;
   localparam int DEB_N = 8;
   localparam int TOG_N = 16;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic far_rst = 1'b1;
   ccp_role_t role = CCP_ROLE_DUAL;
   logic prefer_sink = 1'b0;
   logic capable_sink = 1'b1;
   logic dev_support = 1'b1;
   logic vbus = 1'b0;
   logic legacy = 1'b0;
   logic thru = 1'b0;
   logic att_src, att_snk, found_dev, far_att, def_pwr, tried, lvl;
   int err_count = 0;
   int checked = 0;
   int n, len, runs;
   always #2.5 clk_i = ~clk_i;
   ccp_link_if ccp_link_if_inst ();
   wire lk_up = ccp_link_if_inst.port_pull_up;
   wire lk_dn = ccp_link_if_inst.port_pull_down;
   wire lk_vbus = ccp_link_if_inst.port_vbus_on;
   wire lk_vconn = ccp_link_if_inst.port_vconn_on;
   wire lk_query = ccp_link_if_inst.port_id_query;
   ccp_port ccp_port_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .role_i(role),
      .prefer_sink_i(prefer_sink), .capable_sink_i(capable_sink), .vpd_support_i(dev_support),
      .vbus_present_i(vbus), .debounce_cyc_i(CNT_W'(DEB_N)), .toggle_cyc_i(CNT_W'(TOG_N)),
      .attached_source_o(att_src), .attached_sink_o(att_snk), .vpd_found_o(found_dev),
      .link(ccp_link_if_inst.port));
   ccp_partner ccp_partner_inst (.clk_i(clk_i), .sys_rst_i(far_rst), .legacy_host_i(legacy),
      .charge_thru_i(thru), .debounce_cyc_i(CNT_W'(DEB_N)), .attached_o(far_att),
      .default_power_o(def_pwr), .link(ccp_link_if_inst.partner));
   ccp_link_monitor ccp_link_monitor_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .port_pull_up(lk_up), .port_pull_down(lk_dn), .port_vbus_on(lk_vbus),
      .port_vconn_on(lk_vconn), .port_id_query(lk_query),
      .far_pull_up(ccp_link_if_inst.far_pull_up), .far_pull_down(ccp_link_if_inst.far_pull_down),
      .far_id_valid(ccp_link_if_inst.far_id_valid),
      .far_id_vconn_pwr(ccp_link_if_inst.far_id_vconn_pwr),
      .far_id_charge_thru(ccp_link_if_inst.far_id_charge_thru));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic tick(input int cyc);
      repeat (cyc) @(posedge clk_i);
      #1;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("FAIL %0t ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up;
      if (err_count == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // first run is partial, so only the two full halves after it are measured
   task automatic check_toggle;
      lvl = lk_up;
      for (runs = 0; runs < 3; runs++) begin
         for (len = 0; len < 100 && lk_up === (lvl ^ runs[0]); len++) tick(1);
         if (runs > 0) chk(len >= TOG_N && len <= TOG_N + 1, 1'b1);
      end
   endtask
   // a pull-up run of a full debounce that ends before attach marks the sink trial
   task automatic plug(output logic seen_try);
      seen_try = 1'b0;
      len = 0;
      far_rst = 1'b0;
      for (n = 0; n < 400 && att_src !== 1'b1; n++) begin
         tick(1);
         if (lk_up === 1'b1) begin
            len++;
         end else begin
            if (len >= DEB_N) seen_try = 1'b1;
            len = 0;
         end
      end
      chk({att_src, lk_vbus, lk_vconn}, 3'b111);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      tick(10);
      chk({lk_dn, lk_up, lk_vbus}, 3'b100);
      sys_rst_i = 1'b0;
      check_toggle();
      role = CCP_ROLE_SOURCE;
      tick(60);
      chk({lk_up, lk_vbus, lk_vconn, att_src}, 4'b1000);
      plug(tried);
      chk(tried, 1'b0);
      tick(100);
      chk({far_att, lk_query}, 2'b10);
      far_rst = 1'b1;
      len = 0;
      for (n = 0; n < 60; n++) begin
         tick(1);
         if (lk_up !== 1'b1) len++;
      end
      chk(len, 0);
      chk({lk_vbus, lk_vconn, att_src}, 3'b000);
      role = CCP_ROLE_DUAL;
      plug(tried);
      chk(tried, 1'b0);
      for (n = 0; n < 400 && found_dev !== 1'b1; n++) tick(1);
      chk({found_dev, lk_vbus, lk_up, lk_vconn}, 4'b1011);
      // port reset drops vconn, which the powered device must notice
      sys_rst_i = 1'b1;
      tick(2);
      sys_rst_i = 1'b0;
      for (n = 0; n < 100 && far_att !== 1'b0; n++) tick(1);
      chk(far_att, 1'b0);
      for (n = 0; n < 400 && found_dev !== 1'b1; n++) tick(1);
      chk(found_dev, 1'b1);
      // a charge-through device keeps vbus: rerun the attach with that reply
      thru = 1'b1;
      sys_rst_i = 1'b1;
      tick(2);
      sys_rst_i = 1'b0;
      for (n = 0; n < 400 && att_src !== 1'b1; n++) tick(1);
      tick(60);
      chk({found_dev, lk_vbus, lk_query}, 3'b011);
      far_rst = 1'b1;
      tick(30);
      chk({lk_vbus, lk_vconn, att_src}, 3'b000);
      check_toggle();
      thru = 1'b0;
      role = CCP_ROLE_SINK;
      legacy = 1'b1;
      far_rst = 1'b0;
      tick(60);
      chk({att_snk, def_pwr}, 2'b01);
      vbus = 1'b1;
      for (n = 0; n < 100 && att_snk !== 1'b1; n++) tick(1);
      chk(att_snk, 1'b1);
      vbus = 1'b0;
      tick(20);
      chk(att_snk, 1'b0);
      // let the pull-up loss pass the synchroniser before vbus returns
      far_rst = 1'b1;
      tick(10);
      vbus = 1'b1;
      tick(50);
      chk(att_snk, 1'b0);
      capable_sink = 1'b0;
      for (n = 0; n < 40 && att_snk !== 1'b1; n++) tick(1);
      chk(att_snk, 1'b1);
      vbus = 1'b0;
      capable_sink = 1'b1;
      tick(60);
      chk({att_snk, lk_dn}, 2'b01);
      role = CCP_ROLE_DUAL;
      far_rst = 1'b0;
      tick(60);
      chk({lk_up, att_snk}, 2'b00);
      far_rst = 1'b1;
      tick(6);
      chk(lk_up, 1'b1);
      legacy = 1'b0;
      prefer_sink = 1'b1;
      dev_support = 1'b0;
      tick(40);
      plug(tried);
      chk(tried, 1'b1);
      wrap_up();
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      err_count++;
      wrap_up();
   end
endmodule
